/* File: verilog/ucer_pkg.sv */
// Constants and carrier types of the USB configuration and endpoint register block
package ucer_pkg;

	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned EP_NUM  = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_PTR_MID   = 8'h00;
	localparam logic [7:0] OFS_PTR_UPPER = 8'h04;
	localparam logic [7:0] OFS_CONFIG    = 8'h08;
	localparam logic [7:0] OFS_POWER     = 8'h0C;
	localparam logic [7:0] OFS_INT_STAT  = 8'h10;
	localparam logic [7:0] OFS_INT_MASK  = 8'h14;
	localparam logic [7:0] OFS_EP_BASE   = 8'h40;

	// Configuration register field positions
	localparam int unsigned POS_EYE       = 7;
	localparam int unsigned POS_OEMON     = 6;
	localparam int unsigned POS_STOP_IDLE = 4;
	localparam int unsigned POS_AUTO_SUSP = 0;

	// Power control register field position
	localparam int unsigned POS_MAN_SUSP  = 1;

	// Endpoint register field positions
	localparam int unsigned POS_LOW_SPEED = 7;
	localparam int unsigned POS_RETRY_DIS = 6;
	localparam int unsigned POS_CONDIS    = 4;
	localparam int unsigned POS_RX        = 3;
	localparam int unsigned POS_TX        = 2;
	localparam int unsigned POS_STALL     = 1;
	localparam int unsigned POS_HSHK      = 0;

	// Alignment of the table base address
	localparam int unsigned TABLE_ALIGN_BITS = 9;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Configuration options
	typedef struct packed {
		logic eye_pattern_test_en;
		logic drive_enable_monitor_en;
		logic stop_in_idle;
		logic auto_suspend_on_sleep;
	} ucer_cfg_t;

	// One endpoint control register
	typedef struct packed {
		logic low_speed_direct_en;
		logic nak_retry_disable;
		logic control_transfer_disable;
		logic endpoint_receive_en;
		logic endpoint_transmit_en;
		logic endpoint_stalled_flag;
		logic endpoint_handshake_en;
	} ucer_ep_t;

	// Per-endpoint permissions handed to the transfer engine
	typedef struct packed {
		logic [15:0] rx_allowed;
		logic [15:0] tx_allowed;
		logic [15:0] setup_allowed;
		logic [15:0] handshake_en;
		logic [15:0] stalled;
	} ucer_ep_perm_t;

endpackage

/* File: verilog/ucer_regs.sv */
// Configuration, power control and endpoint control registers of the USB controller
`timescale 1ns/10ps

module ucer_regs (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata,
	// Status from the rest of the controller, same clock
	input  wire logic                  host_mode,
	input  wire logic                  idle_mode,
	input  wire logic                  sleep_mode,
	input  wire logic                  line_drive_active,
	input  wire logic [6:0]            table_base_low,
	input  wire logic [15:0]           stall_event,
	// Controls to the rest of the controller
	output logic [31:0]                table_base_addr,
	output ucer_pkg::ucer_cfg_t        cfg_out,
	output logic                       eye_pattern_active,
	output logic                       oe_monitor,
	output logic                       module_run_en,
	output logic                       module_suspend,
	output logic                       usb_clk_en,
	output logic                       low_speed_direct,
	output logic                       nak_retry_en,
	output ucer_pkg::ucer_ep_perm_t    ep_perm,
	output logic                       irq
);

	// Stored registers
	logic [7:0]                 table_base_bits_mid;
	logic [7:0]                 table_base_bits_upper;
	ucer_pkg::ucer_cfg_t        cfg;
	logic                       manual_suspend;
	logic [15:0]                int_status;
	logic [15:0]                int_mask;
	ucer_pkg::ucer_ep_t         ep_reg [ucer_pkg::EP_NUM];

	// Address decode
	wire logic                  sel_ptr_mid;
	wire logic                  sel_ptr_upper;
	wire logic                  sel_config;
	wire logic                  sel_power;
	wire logic                  sel_int_stat;
	wire logic                  sel_int_mask;
	wire logic                  sel_ep_range;
	wire logic [3:0]            ep_index;
	wire logic                  wr_ptr_mid;
	wire logic                  wr_ptr_upper;
	wire logic                  wr_config;
	wire logic                  wr_power;
	wire logic                  wr_int_stat;
	wire logic                  wr_int_mask;

	// Derived controls
	wire logic                  next_suspend;
	wire logic                  next_run;
	wire logic [15:0]           ep_rx;
	wire logic [15:0]           ep_tx;
	wire logic [15:0]           ep_setup;
	wire logic [15:0]           ep_hshk;
	wire logic [15:0]           ep_stall;
	wire logic                  next_irq;
	wire logic [31:0]           next_table_base;

	// Read selection
	wire logic [31:0]           rd_ptr_mid;
	wire logic [31:0]           rd_ptr_upper;
	wire logic [31:0]           rd_config;
	wire logic [31:0]           rd_power;
	wire logic [31:0]           rd_int_stat;
	wire logic [31:0]           rd_int_mask;
	wire logic [31:0]           rd_ep;
	wire logic [31:0]           next_rdata;

	// Decode of word addresses; endpoint n sits at base plus four times n
	assign sel_ptr_mid   = (reg_addr == ucer_pkg::OFS_PTR_MID);
	assign sel_ptr_upper = (reg_addr == ucer_pkg::OFS_PTR_UPPER);
	assign sel_config    = (reg_addr == ucer_pkg::OFS_CONFIG);
	assign sel_power     = (reg_addr == ucer_pkg::OFS_POWER);
	assign sel_int_stat  = (reg_addr == ucer_pkg::OFS_INT_STAT);
	assign sel_int_mask  = (reg_addr == ucer_pkg::OFS_INT_MASK);
	assign sel_ep_range  = (reg_addr[7:6] == ucer_pkg::OFS_EP_BASE[7:6]) &&
	                       (reg_addr[1:0] == 2'h0);
	assign ep_index      = reg_addr[5:2];

	// Write strobes per register
	assign wr_ptr_mid    = reg_wr && sel_ptr_mid;
	assign wr_ptr_upper  = reg_wr && sel_ptr_upper;
	assign wr_config     = reg_wr && sel_config;
	assign wr_power      = reg_wr && sel_power;
	assign wr_int_stat   = reg_wr && sel_int_stat;
	assign wr_int_mask   = reg_wr && sel_int_mask;

	// Descriptor table pointer bytes, upper bits of wdata dropped
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			table_base_bits_mid   <= ucer_pkg::RST_BYTE;
			table_base_bits_upper <= ucer_pkg::RST_BYTE;
		end else begin
			if (wr_ptr_mid)
				table_base_bits_mid <= reg_wdata[7:0];
			if (wr_ptr_upper)
				table_base_bits_upper <= reg_wdata[7:0];
		end
	end

	// Configuration options; bits 5 and 3 to 1 are not stored
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '0;
		end else if (wr_config) begin
			cfg.eye_pattern_test_en     <= reg_wdata[ucer_pkg::POS_EYE];
			cfg.drive_enable_monitor_en <= reg_wdata[ucer_pkg::POS_OEMON];
			cfg.stop_in_idle            <= reg_wdata[ucer_pkg::POS_STOP_IDLE];
			cfg.auto_suspend_on_sleep   <= reg_wdata[ucer_pkg::POS_AUTO_SUSP];
		end
	end

	// Software suspend control
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			manual_suspend <= 1'b0;
		else if (wr_power)
			manual_suspend <= reg_wdata[ucer_pkg::POS_MAN_SUSP];
	end

	// Endpoint registers, one per endpoint
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_ep
			wire logic ep_wr;
			assign ep_wr = reg_wr && sel_ep_range && (ep_index == 4'(gi));

			// Control bits; host-only options exist on endpoint 0 alone.
			// The engine's stall set comes last, so it wins over a software write
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					ep_reg[gi] <= '0;
				end else begin
					if (ep_wr) begin
						ep_reg[gi].low_speed_direct_en      <= (gi == 0) &&
							reg_wdata[ucer_pkg::POS_LOW_SPEED];
						ep_reg[gi].nak_retry_disable        <= (gi == 0) &&
							reg_wdata[ucer_pkg::POS_RETRY_DIS];
						ep_reg[gi].control_transfer_disable <= reg_wdata[ucer_pkg::POS_CONDIS];
						ep_reg[gi].endpoint_receive_en      <= reg_wdata[ucer_pkg::POS_RX];
						ep_reg[gi].endpoint_transmit_en     <= reg_wdata[ucer_pkg::POS_TX];
						ep_reg[gi].endpoint_stalled_flag    <= reg_wdata[ucer_pkg::POS_STALL];
						ep_reg[gi].endpoint_handshake_en    <= reg_wdata[ucer_pkg::POS_HSHK];
					end
					if (stall_event[gi])
						ep_reg[gi].endpoint_stalled_flag <= 1'b1;
				end
			end

			// Permissions seen by the transfer engine for this endpoint
			assign ep_rx[gi]    = ep_reg[gi].endpoint_receive_en;
			assign ep_tx[gi]    = ep_reg[gi].endpoint_transmit_en;
			assign ep_setup[gi] = ep_rx[gi] && ep_tx[gi] &&
			                      !ep_reg[gi].control_transfer_disable;
			assign ep_hshk[gi]  = ep_reg[gi].endpoint_handshake_en;
			assign ep_stall[gi] = ep_reg[gi].endpoint_stalled_flag;
		end
	endgenerate

	// Sticky stall interrupt status, cleared by writing one; an event wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			int_status <= ucer_pkg::RST_HALF;
		else
			int_status <= (int_status & ~({16{wr_int_stat}} & reg_wdata[15:0]))
			              | stall_event;
	end

	// Interrupt mask
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			int_mask <= ucer_pkg::RST_HALF;
		else if (wr_int_mask)
			int_mask <= reg_wdata[15:0];
	end

	// Suspend and run decisions from power state and options
	assign next_suspend = manual_suspend ||
	                      (cfg.auto_suspend_on_sleep && sleep_mode);
	assign next_run     = !next_suspend &&
	                      !(cfg.stop_in_idle && idle_mode);
	assign next_irq     = |(int_status & int_mask);

	// Full base address; the low nine bits are forced to zero
	assign next_table_base = {table_base_bits_upper,
	                          table_base_bits_mid,
	                          table_base_low,
	                          {ucer_pkg::TABLE_ALIGN_BITS{1'b0}}};

	// Registered power and test controls
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			module_suspend     <= 1'b0;
			usb_clk_en         <= 1'b0;
			module_run_en      <= 1'b0;
			eye_pattern_active <= 1'b0;
			oe_monitor         <= 1'b0;
		end else begin
			module_suspend     <= next_suspend;
			usb_clk_en         <= !next_suspend;
			module_run_en      <= next_run;
			eye_pattern_active <= cfg.eye_pattern_test_en && next_run;
			oe_monitor         <= cfg.drive_enable_monitor_en &&
			                      line_drive_active;
		end
	end

	// Registered host-mode options of endpoint 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_speed_direct <= 1'b0;
			nak_retry_en     <= 1'b0;
		end else begin
			low_speed_direct <= host_mode && ep_reg[0].low_speed_direct_en;
			nak_retry_en     <= host_mode && !ep_reg[0].nak_retry_disable;
		end
	end

	// Registered endpoint permissions, base address, options and interrupt
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ep_perm         <= '0;
			table_base_addr <= ucer_pkg::RST_WORD;
			cfg_out         <= '0;
			irq             <= 1'b0;
		end else begin
			ep_perm         <= '{rx_allowed: ep_rx, tx_allowed: ep_tx,
			                     setup_allowed: ep_setup, handshake_en: ep_hshk,
			                     stalled: ep_stall};
			table_base_addr <= next_table_base;
			cfg_out         <= cfg;
			irq             <= next_irq;
		end
	end

	// Read words; every bit not listed reads zero
	assign rd_ptr_mid   = {24'h00_0000, table_base_bits_mid};
	assign rd_ptr_upper = {24'h00_0000, table_base_bits_upper};
	assign rd_config    = {24'h00_0000,
	                       cfg.eye_pattern_test_en,
	                       cfg.drive_enable_monitor_en,
	                       1'b0,
	                       cfg.stop_in_idle,
	                       3'h0,
	                       cfg.auto_suspend_on_sleep};
	assign rd_power     = {30'h0, manual_suspend, 1'b0};
	assign rd_int_stat  = {16'h0000, int_status};
	assign rd_int_mask  = {16'h0000, int_mask};
	assign rd_ep        = {24'h00_0000,
	                       ep_reg[ep_index].low_speed_direct_en,
	                       ep_reg[ep_index].nak_retry_disable,
	                       1'b0,
	                       ep_reg[ep_index].control_transfer_disable,
	                       ep_reg[ep_index].endpoint_receive_en,
	                       ep_reg[ep_index].endpoint_transmit_en,
	                       ep_reg[ep_index].endpoint_stalled_flag,
	                       ep_reg[ep_index].endpoint_handshake_en};

	// Read mux; unmapped addresses answer zero
	assign next_rdata = !reg_rd       ? ucer_pkg::RST_WORD :
	                    sel_ptr_mid   ? rd_ptr_mid   :
	                    sel_ptr_upper ? rd_ptr_upper :
	                    sel_config    ? rd_config    :
	                    sel_power     ? rd_power     :
	                    sel_int_stat  ? rd_int_stat  :
	                    sel_int_mask  ? rd_int_mask  :
	                    sel_ep_range  ? rd_ep        :
	                    ucer_pkg::RST_WORD;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= ucer_pkg::RST_WORD;
		else
			reg_rdata <= next_rdata;
	end

endmodule

/* File: bench/ucer_regs_monitor.sv */
// Port-level checker of the USB configuration and endpoint register block
`timescale 1ns/10ps

module ucer_regs_monitor (
	input wire logic                   mclk,
	input wire logic                   rst_n,
	input wire logic                   reg_rd,
	input wire logic [31:0]            reg_rdata,
	input wire logic                   host_mode,
	input wire logic                   idle_mode,
	input wire logic                   sleep_mode,
	input wire logic                   line_drive_active,
	input wire logic [6:0]             table_base_low,
	input wire logic [15:0]            stall_event,
	input wire logic [31:0]            table_base_addr,
	input wire ucer_pkg::ucer_cfg_t    cfg_out,
	input wire logic                   eye_pattern_active,
	input wire logic                   oe_monitor,
	input wire logic                   module_run_en,
	input wire logic                   module_suspend,
	input wire logic                   usb_clk_en,
	input wire logic                   low_speed_direct,
	input wire logic                   nak_retry_en,
	input wire ucer_pkg::ucer_ep_perm_t ep_perm
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Table base keeps the low nine bits zero and follows the lower page
	property p_align;
		$past(rst_n) |-> table_base_addr[15:0] == {$past(table_base_low), 9'h000};
	endproperty
	a_align: assert property (p_align) else $error("table base low bits wrong");
	// Read data is zero outside the answer cycle and above bit 15
	property p_rdata;
		(!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) and (reg_rdata[31:16] == 16'h0000);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data not zero");
	// Drive monitor mirrors the line drive while enabled
	property p_oemon;
		$stable(cfg_out.drive_enable_monitor_en) |->
			oe_monitor == (cfg_out.drive_enable_monitor_en && $past(line_drive_active));
	endproperty
	a_oemon: assert property (p_oemon) else $error("drive monitor mismatch");
	// Eye test runs only while enabled
	property p_eye;
		eye_pattern_active |-> cfg_out.eye_pattern_test_en || $past(cfg_out.eye_pattern_test_en);
	endproperty
	a_eye: assert property (p_eye) else $error("eye test without enable");
	// Stop in idle halts the module
	property p_idle;
		cfg_out.stop_in_idle && $past(cfg_out.stop_in_idle) && $past(idle_mode) |-> !module_run_en;
	endproperty
	a_idle: assert property (p_idle) else $error("module runs in idle");
	// Automatic suspend on sleep, clock gated with suspend
	property p_susp;
		$past(rst_n) |-> (usb_clk_en == !module_suspend) &&
			(!(cfg_out.auto_suspend_on_sleep && $past(sleep_mode)) || module_suspend);
	endproperty
	a_susp: assert property (p_susp) else $error("suspend or clock wrong");
	// Host-only endpoint 0 options act only in host mode
	property p_host;
		(low_speed_direct |-> $past(host_mode)) and (!$past(host_mode) |-> !nak_retry_en);
	endproperty
	a_host: assert property (p_host) else $error("host option outside host mode");
	// Setup needs both directions enabled
	property p_setup;
		(ep_perm.setup_allowed & ~(ep_perm.rx_allowed & ep_perm.tx_allowed)) == 16'h0000;
	endproperty
	a_setup: assert property (p_setup) else $error("setup allowed wrongly");
	// Stall event shows in the stall flags two cycles on
	property p_stall;
		|stall_event |-> ##2 ((ep_perm.stalled & $past(stall_event, 2)) == $past(stall_event, 2));
	endproperty
	a_stall: assert property (p_stall) else $error("stall flag missing");
endmodule

/* File: bench/ucer_link_model.sv */
// Model of the controller side: modes, line drive and stall events
`timescale 1ns/10ps

module ucer_link_model (
	input wire logic   mclk,
	output logic       host_mode,
	output logic       idle_mode,
	output logic       sleep_mode,
	output logic       line_drive_active,
	output logic [6:0] table_base_low,
	output logic [15:0] stall_event
);
	// Quiet bus, device mode, fixed lower table page
	initial begin
		{host_mode, idle_mode, sleep_mode, line_drive_active} = 4'h0;
		table_base_low = 7'h5B;
		stall_event = 16'h0000;
	end

	// Mode change just after an edge
	task automatic set_modes(input logic h, input logic i, input logic s);
		@(posedge mclk);
		host_mode <= h;
		idle_mode <= i;
		sleep_mode <= s;
	endtask

	// Drive the lines for a packet of n cycles
	task automatic transmit(input int n);
		@(posedge mclk);
		line_drive_active <= 1'b1;
		repeat (n) @(posedge mclk);
		line_drive_active <= 1'b0;
	endtask

	// One-cycle stall pulse on one endpoint
	task automatic stall(input int ep);
		@(posedge mclk);
		stall_event <= 16'h0001 << ep;
		@(posedge mclk);
		stall_event <= 16'h0000;
	endtask
endmodule

/* File: bench/tb_usb_config_endpoint_regs.sv */
// Self-checking bench of the USB configuration and endpoint register block
`timescale 1ns/10ps

module tb_usb_config_endpoint_regs;
	logic        mclk, rst_n, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, table_base_addr;
	logic        host_mode, idle_mode, sleep_mode, line_drive_active;
	logic [6:0]  table_base_low;
	logic [15:0] stall_event;
	ucer_pkg::ucer_cfg_t cfg_out;
	ucer_pkg::ucer_ep_perm_t ep_perm;
	logic        eye_pattern_active, oe_monitor, module_run_en, module_suspend;
	logic        usb_clk_en, low_speed_direct, nak_retry_en, irq;
	int          miscompares = 0;
	int          checks_done = 0;

	ucer_regs ucer_regs_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .host_mode, .idle_mode, .sleep_mode, .line_drive_active,
		.table_base_low, .stall_event, .table_base_addr, .cfg_out, .eye_pattern_active,
		.oe_monitor, .module_run_en, .module_suspend, .usb_clk_en, .low_speed_direct,
		.nak_retry_en, .ep_perm, .irq);
	ucer_link_model ucer_link_model_inst (.mclk, .host_mode, .idle_mode, .sleep_mode,
		.line_drive_active, .table_base_low, .stall_event);

	// Clock at 25 ns
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic finish_test();
		$display("checks %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask

	// Let derived outputs follow a register change
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask

	// Hang guard
	initial begin
		#(5000 * 25);
		miscompares++;
		finish_test();
	end

	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 0; a < 6; a++) rd(8'(4 * a), 32'h0000_0000, "reset reg");
		for (int n = 0; n < 16; n++) rd(8'h40 + 8'(4 * n), 32'h0000_0000, "reset ep");
		chk("base", {16'h0000, 7'h5B, 9'h000}, table_base_addr);
		wr(8'h00, 32'hFFFF_FFA5);
		wr(8'h04, 32'hDEAD_BE3C);
		wr(8'h02, 32'h0000_0077);
		rd(8'h00, 32'h0000_00A5, "ptr mid");
		rd(8'h04, 32'h0000_003C, "ptr upper");
		settle();
		chk("base", {8'h3C, 8'hA5, 7'h5B, 9'h000}, table_base_addr);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0000_0000, "unmapped");
		rd(8'h41, 32'h0000_0000, "misaligned");
		wr(8'h08, 32'hFFFF_FFFF);
		rd(8'h08, 32'h0000_00D1, "config");
		settle();
		chk("cfg", 32'h0000_000F, {28'h0, cfg_out});
		chk("eye", 32'h1, {31'h0, eye_pattern_active});
		fork
			ucer_link_model_inst.transmit(4);
			begin
				settle();
				chk("oe mon", 32'h1, {31'h0, oe_monitor});
			end
		join
		ucer_link_model_inst.set_modes(1'b0, 1'b1, 1'b0);
		settle();
		chk("run idle", 32'h0, {31'h0, module_run_en});
		chk("oe mon off", 32'h0, {31'h0, oe_monitor});
		ucer_link_model_inst.set_modes(1'b0, 1'b0, 1'b1);
		settle();
		chk("susp sleep", 32'h1, {31'h0, module_suspend});
		chk("clk sleep", 32'h0, {31'h0, usb_clk_en});
		wr(8'h08, 32'h0000_0000);
		ucer_link_model_inst.set_modes(1'b0, 1'b1, 1'b1);
		settle();
		chk("susp off", 32'h0, {31'h0, module_suspend});
		chk("run idle off", 32'h1, {31'h0, module_run_en});
		chk("eye off", 32'h0, {31'h0, eye_pattern_active});
		wr(8'h0C, 32'h0000_0002);
		rd(8'h0C, 32'h0000_0002, "power");
		settle();
		chk("man susp", 32'h2, {30'h0, module_suspend, usb_clk_en});
		wr(8'h0C, 32'h0000_0000);
		ucer_link_model_inst.set_modes(1'b0, 1'b0, 1'b0);
		settle();
		chk("resume", 32'h1, {31'h0, usb_clk_en});
		for (int n = 0; n < 16; n++) begin
			wr(8'h40 + 8'(4 * n), 32'hFFFF_FFFF);
			rd(8'h40 + 8'(4 * n), (n == 0) ? 32'h0000_00DF : 32'h0000_001F, "ep all");
		end
		settle();
		chk("rx tx", 32'hFFFF_FFFF, {ep_perm.rx_allowed, ep_perm.tx_allowed});
		chk("setup hs", 32'h0000_FFFF, {ep_perm.setup_allowed, ep_perm.handshake_en});
		chk("stalled", 32'h0000_FFFF, {16'h0, ep_perm.stalled});
		for (int n = 0; n < 16; n++) wr(8'h40 + 8'(4 * n), n[0] ? 32'h0000_000C : 32'h0000_0009);
		wr(8'h10, 32'h0000_FFFF);
		settle();
		chk("rx tx", 32'hFFFF_AAAA, {ep_perm.rx_allowed, ep_perm.tx_allowed});
		chk("setup hs", 32'hAAAA_5555, {ep_perm.setup_allowed, ep_perm.handshake_en});
		chk("stalled", 32'h0, {16'h0, ep_perm.stalled});
		wr(8'h40, 32'h0000_00C9);
		settle();
		chk("dev opts", 32'h0, {30'h0, low_speed_direct, nak_retry_en});
		ucer_link_model_inst.set_modes(1'b1, 1'b0, 1'b0);
		settle();
		chk("host opts", 32'h2, {30'h0, low_speed_direct, nak_retry_en});
		wr(8'h40, 32'h0000_0009);
		settle();
		chk("host retry", 32'h1, {30'h0, low_speed_direct, nak_retry_en});
		wr(8'h14, 32'h0000_0020);
		ucer_link_model_inst.stall(5);
		settle();
		chk("irq", 32'h1, {31'h0, irq});
		rd(8'h10, 32'h0000_0020, "int status");
		rd(8'h54, 32'h0000_000E, "ep5 stall");
		wr(8'h14, 32'h0000_0000);
		settle();
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h14, 32'h0000_0020);
		wr(8'h10, 32'h0000_0020);
		settle();
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(8'h10, 32'h0000_0000, "int status");
		finish_test();
	end
endmodule

bind ucer_regs ucer_regs_monitor ucer_regs_monitor_inst (.mclk, .rst_n, .reg_rd, .reg_rdata,
	.host_mode, .idle_mode, .sleep_mode, .line_drive_active, .table_base_low, .stall_event,
	.table_base_addr, .cfg_out, .eye_pattern_active, .oe_monitor, .module_run_en,
	.module_suspend, .usb_clk_en, .low_speed_direct, .nak_retry_en, .ep_perm);
